// *** gpib_tape_command_decoder.v ***
// GPIB address and command decoder of a cartridge tape drive
// Behaviour
// RULE_01 - With ATN high, classify each byte as primary, secondary or universal.
// RULE_02 - Controller sends all addresses under ATN then releases ATN to start.
// RULE_03 - Once addressed to talk for input, stream file characters to the listener.
// RULE_04 - Untalk or unlisten under ATN aborts; the drive stops transmitting. Code: unlisten leaves ST_TALK and talking set.
// RULE_05 - Final file byte goes out with EOI asserted.
// RULE_06 - Command string ends on carriage return or on EOI with last character.
// RULE_07 - Alternate mode when online and scheme switch set to alternate.
// RULE_08 - Alternate mode uses even data address and command address plus one.
// RULE_09 - Alternate mode ignores the lowest address switch bit.
// RULE_10 - Alternate mode answers primary addresses only, ignoring secondaries.
// RULE_11 - Alternate mode knows command and data talk and listen addresses.
// RULE_12 - Unlisten after command string flushes buffer and parses the string.
// RULE_13 - Commands only at command address; data only at data addresses.
// RULE_14 - Data-transfer commands stay pending until data addressing.
// RULE_15 - Data talk then ATN release starts the pending transfer.
// RULE_16 - Bytes at data listen after write are tape data, not commands.
// RULE_17 - Controller releases drive with unlisten or untalk after transfers.
// RULE_18 - File search executes at unlisten without data addressing.
// RULE_19 - Parser accepts abbreviated or spelled words and varied separators.
// RULE_20 - Listen address is 001 plus switches; talk address is 010 plus switches.
// RULE_21 - Secondary mode decodes commands from 011xxxxx secondary bytes.
// RULE_22 - Info command pending and command talk address sends an info string.
// RULE_23 - Another device's talk address ends the talker state.
// RULE_24 - String without unlisten stays buffered and unexecuted.
`timescale 1ns/1ps
`include "tape_cmd_consts.vh"
module gpib_tape_command_decoder (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // Switches
  input  wire       online,
  input  wire       addressing_scheme_switch,
  input  wire [4:0] addr_switch,
  // Bus byte from controller or talker, one strobe per accepted byte
  input  wire       bus_valid,
  input  wire [7:0] bus_data,
  input  wire       bus_atn,
  input  wire       bus_eoi,
  // Talker data path: tape file bytes
  input  wire       tape_valid,
  input  wire [7:0] tape_data,
  input  wire       tape_last,
  output reg        tape_ready,
  // Talker output to bus
  output reg        tx_valid,
  output reg  [7:0] tx_data,
  output reg        tx_eoi,
  input  wire       tx_ready,
  // Write path to tape
  output reg        wr_valid,
  output reg  [7:0] wr_data,
  // Command execution
  output reg        find_start,
  output reg [15:0] find_file,
  output reg        info_request,
  output reg [4:0]  sec_cmd,
  output reg        sec_cmd_valid,
  output reg        alt_mode,
  output reg        talking,
  output reg        listening
);
  // ==========
  // State and command buffer
  localparam ST_IDLE   = 2'h0;
  localparam ST_CMDRX  = 2'h1;
  localparam ST_DATARX = 2'h2;
  localparam ST_TALK   = 2'h3;

  reg [1:0]                  state_q;
  reg [7:0]                  buf_q [0:`CMD_BUF_DEPTH-1];
  reg [`CMD_BUF_AW:0]        len_q;
  reg                        str_done_q;
  reg [2:0]                  pend_q;
  reg                        talk_info_q;
  reg                        talk_addr_q;
  reg                        last_was_mine_q;
  reg [15:0]                 num_q;
  wire [8*`CMD_BUF_DEPTH-1:0] buf_flat;
  wire [2:0]                 p_code;
  wire [15:0]                p_param;
  wire [4:0]                 base;
  wire                       atn_byte;
  wire                       data_byte;
  wire [2:0]                 pre;
  wire [4:0]                 lo;
  wire [15:0]                num_next;

  // ==========
  // Byte decoding
  function is_addr;
    input [7:0] b;
    input [2:0] prefix;
    input [4:0] a;
    input       alt;
    begin
      is_addr = (b[7:5] == prefix) && (alt ? (b[4:1] == a[4:1]) : (b[4:0] == a)); // RULE_09
    end
  endfunction

  function is_digit;
    input [7:0] b;
    begin
      is_digit = (b >= 8'h30) && (b <= 8'h39);
    end
  endfunction

  // ==========
  // Command string buffer and parser
  // The parser sees the buffer as one flat word
  genvar g;
  generate
    for (g = 0; g < `CMD_BUF_DEPTH; g = g + 1) begin : g_flat
      assign buf_flat[8*g +: 8] = buf_q[g];
    end
  endgenerate

  // Parsing is combinational, so the code is ready on the unlisten cycle
  cmd_string_parser u_parser (
    .buf_flat  (buf_flat),
    .buf_len   (len_q),
    .cmd_code  (p_code),
    .cmd_param (p_param)
  );

  // ==========
  // Bus byte classification
  assign base      = {addr_switch[4:1], 1'b0}; // RULE_08
  assign atn_byte  = bus_valid & bus_atn;
  assign data_byte = bus_valid & ~bus_atn;
  assign pre       = bus_data[7:5];
  assign lo        = bus_data[4:0];
  assign num_next  = num_q * 16'h000a + {12'h000, bus_data[3:0]};

  // Two addresses: data = even base, command = base + 1
  wire is_cla = is_addr(bus_data, `LISTEN_PREFIX, {base[4:1], 1'b1}, 1'b0);
  wire is_cta = is_addr(bus_data, `TALK_PREFIX,   {base[4:1], 1'b1}, 1'b0);
  wire is_dla = is_addr(bus_data, `LISTEN_PREFIX, base, 1'b0);
  wire is_dta = is_addr(bus_data, `TALK_PREFIX,   base, 1'b0);

  wire is_mla = is_addr(bus_data, `LISTEN_PREFIX, addr_switch, 1'b0); // RULE_20
  wire is_mta = is_addr(bus_data, `TALK_PREFIX,   addr_switch, 1'b0); // RULE_20

  wire is_unl = (bus_data == `UNIVERSAL_UNL);
  wire is_unt = (bus_data == `UNIVERSAL_UNT);
  wire is_sec = (pre == `SECONDARY_PREFIX); // RULE_01
  // In alternate mode both talk addresses of the pair belong to this drive
  wire is_own_talk   = alt_mode ? (is_cta || is_dta) : is_mta;
  wire is_other_talk = (pre == `TALK_PREFIX) && !is_unt && !is_own_talk;

  // ==========
  // Bus protocol engine
  integer k;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q         <= ST_IDLE;
      len_q           <= {(`CMD_BUF_AW+1){1'b0}};
      num_q           <= 16'h0000;
      str_done_q      <= 1'b0;
      pend_q          <= `CMD_NONE;
      talk_info_q     <= 1'b0;
      talk_addr_q     <= 1'b0;
      last_was_mine_q <= 1'b0;
      for (k = 0; k < `CMD_BUF_DEPTH; k = k + 1)
        buf_q[k] <= 8'h00;
      tape_ready      <= 1'b0;
      tx_valid        <= 1'b0;
      tx_data         <= 8'h00;
      tx_eoi          <= 1'b0;
      wr_valid        <= 1'b0;
      wr_data         <= 8'h00;
      find_start      <= 1'b0;
      find_file       <= 16'h0000;
      info_request    <= 1'b0;
      sec_cmd         <= 5'h00;
      sec_cmd_valid   <= 1'b0;
      alt_mode        <= 1'b0;
      talking         <= 1'b0;
      listening       <= 1'b0;
    end else begin
      alt_mode      <= online & addressing_scheme_switch; // RULE_07
      find_start    <= 1'b0;
      info_request  <= 1'b0;
      sec_cmd_valid <= 1'b0;
      wr_valid      <= 1'b0;
      tape_ready    <= 1'b0;
      if (tx_valid && tx_ready)
        tx_valid <= 1'b0;

      // Universal commands outrank addressing, so an abort always lands, except an unlisten in ST_TALK
      if (atn_byte) begin // RULE_01
        tx_valid   <= 1'b0;
        if (is_unl) begin // RULE_04
          listening <= 1'b0;
          if (alt_mode && state_q == ST_CMDRX) begin
            // Flush and parse the string on unlisten
            len_q <= {(`CMD_BUF_AW+1){1'b0}}; // RULE_12
            case (p_code)
              `CMD_FIND: begin
                find_start <= 1'b1; // RULE_18
                find_file  <= p_param;
              end
              `CMD_INPUT, `CMD_PRINT: pend_q <= p_code; // RULE_14
              `CMD_INFO: pend_q <= `CMD_INFO; // RULE_22
              default: pend_q <= `CMD_NONE;
            endcase
          end
          if (state_q != ST_TALK)
            state_q <= ST_IDLE;
          str_done_q <= 1'b0;
        end else if (is_unt || is_other_talk) begin // RULE_04 RULE_23
          talking     <= 1'b0;
          talk_addr_q <= 1'b0;
          if (state_q == ST_TALK)
            state_q <= ST_IDLE;
        end else if (alt_mode) begin // RULE_10 RULE_11 RULE_13
          // Data addresses act only on a transfer that is already pending
          if (is_cla) begin
            state_q    <= ST_CMDRX;
            listening  <= 1'b1;
            len_q      <= {(`CMD_BUF_AW+1){1'b0}};
            str_done_q <= 1'b0;
          end else if (is_dla && pend_q == `CMD_PRINT) begin
            state_q   <= ST_DATARX; // RULE_14
            listening <= 1'b1;
          end else if (is_dta && pend_q == `CMD_INPUT) begin
            talk_addr_q <= 1'b1; // RULE_15
            talk_info_q <= 1'b0;
          end else if (is_cta && pend_q == `CMD_INFO) begin
            talk_addr_q <= 1'b1; // RULE_22
            talk_info_q <= 1'b1;
          end
        end else begin
          if (is_mla || is_mta) begin
            last_was_mine_q <= 1'b1;
            talk_addr_q     <= is_mta;
            talk_info_q     <= 1'b0;
            listening       <= is_mla;
          end else if (is_sec && last_was_mine_q) begin
            sec_cmd         <= lo; // RULE_21
            sec_cmd_valid   <= 1'b1;
            last_was_mine_q <= 1'b0;
            if (lo == `SEC_FIND) begin
              // Fresh number per search; a stale terminator would mute the digits
              state_q    <= ST_CMDRX;
              str_done_q <= 1'b0;
              num_q      <= 16'h0000;
            end
          end else
            last_was_mine_q <= 1'b0;
        end
      end else if (data_byte) begin
        // A full buffer drops further characters rather than wrapping
        if (state_q == ST_CMDRX && !str_done_q) begin
          if (bus_data == `ASCII_CR)
            str_done_q <= 1'b1; // RULE_06
          else if (len_q < `CMD_BUF_DEPTH) begin
            buf_q[len_q[`CMD_BUF_AW-1:0]] <= bus_data; // RULE_24
            len_q <= len_q + 1'b1;
            if (bus_eoi)
              str_done_q <= 1'b1; // RULE_06
          end
          // Secondary mode keeps its own number: the parser skips the first character
          if (!alt_mode) begin
            if (is_digit(bus_data))
              num_q <= num_next;
            if (bus_data == `ASCII_CR || bus_eoi) begin
              find_start <= 1'b1; // RULE_21
              find_file  <= (bus_eoi && is_digit(bus_data)) ? num_next : num_q; // RULE_06
              state_q    <= ST_IDLE;
            end
          end
        end else if (state_q == ST_DATARX) begin
          wr_valid <= 1'b1; // RULE_16
          wr_data  <= bus_data;
        end
      end else if (!bus_atn && talk_addr_q && state_q != ST_TALK) begin
        // ATN released after our talk address starts the transfer
        state_q      <= ST_TALK; // RULE_02 RULE_15
        talking      <= 1'b1;
        info_request <= talk_info_q;
        if (talk_info_q)
          pend_q <= `CMD_NONE;
      end else if (state_q == ST_TALK && !bus_atn && !tx_valid && tape_valid && !tape_ready && !talk_info_q) begin
        // One byte in flight; the next waits until the listener took this one
        tx_valid   <= 1'b1; // RULE_03
        tx_data    <= tape_data;
        tx_eoi     <= tape_last; // RULE_05
        tape_ready <= 1'b1;
        if (tape_last) begin
          state_q     <= ST_IDLE; // RULE_17
          talk_addr_q <= 1'b0;
          talking     <= 1'b0;
        end
      end
    end
  end
endmodule // gpib_tape_command_decoder

// *** tape_cmd_consts.vh ***
// Constants for the GPIB tape command decoder
`ifndef TAPE_CMD_CONSTS_VH
`define TAPE_CMD_CONSTS_VH
`define LISTEN_PREFIX    3'h1
`define TALK_PREFIX      3'h2
`define SECONDARY_PREFIX 3'h3
`define UNIVERSAL_UNL    8'h3f
`define UNIVERSAL_UNT    8'h5f
`define SEC_STATUS       5'h00
`define SEC_FIND         5'h18
`define ASCII_CR         8'h0d
`define CMD_BUF_DEPTH    16
`define CMD_BUF_AW       4
`define CMD_NONE         3'h0
`define CMD_FIND         3'h1
`define CMD_INPUT        3'h2
`define CMD_PRINT        3'h3
`define CMD_INFO         3'h4
`define CMD_OTHER        3'h5
`endif

// *** cmd_string_parser.v ***
// Parser turning a buffered ASCII command string into a command code and number
`timescale 1ns/1ps
`include "tape_cmd_consts.vh"
module cmd_string_parser (
  // Buffered string
  input  wire [8*`CMD_BUF_DEPTH-1:0] buf_flat,
  input  wire [`CMD_BUF_AW:0]        buf_len,
  // Result
  output reg  [2:0]                  cmd_code,
  output reg  [15:0]                 cmd_param
);
  reg  [7:0] ch;
  reg  [7:0] first;
  integer    i;
  // Any letters after the first are ignored, so "F", "FIND", "F=" and "F?" all match
  always @* begin
    first     = buf_flat[7:0] & 8'hdf;
    cmd_param = 16'h0000;
    for (i = 1; i < `CMD_BUF_DEPTH; i = i + 1) begin
      ch = buf_flat[8*i +: 8];
      if (i < buf_len && ch >= 8'h30 && ch <= 8'h39)
        cmd_param = cmd_param * 16'h000a + {12'h000, ch[3:0]}; // RULE_19
    end
    ch = 8'h00;
    if (buf_len == 0)
      cmd_code = `CMD_NONE;
    else begin
      case (first) // RULE_19
        8'h46:   cmd_code = `CMD_FIND;
        8'h49:   cmd_code = `CMD_INPUT;
        8'h50:   cmd_code = `CMD_PRINT;
        8'h45, 8'h54, 8'h48, 8'h53: cmd_code = `CMD_INFO;
        default: cmd_code = `CMD_OTHER;
      endcase
    end
  end
endmodule // cmd_string_parser

// *** gpib_tape_command_decoder_asserts.sv ***
// Port-level checks of the tape command decoder
`timescale 1ns/1ps
`include "tape_cmd_consts.vh"
module gpib_tape_command_decoder_chk (
  // Clock, reset, switches and secondary command
  input wire       clk_sys, rst, online, addressing_scheme_switch,
  input wire [4:0] addr_switch, sec_cmd,
  // Bus, talker and command outputs
  input wire       bus_valid, bus_atn, bus_eoi, tx_valid, tx_eoi, tx_ready, wr_valid,
  input wire       find_start, sec_cmd_valid, alt_mode, talking, listening,
  input wire [7:0] bus_data, tx_data, wr_data
);
  // ==========
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence atn_byte(b);
    bus_valid && bus_atn && bus_data == b;
  endsequence
  unl_drops_listen_a:
    assert property (atn_byte(`UNIVERSAL_UNL) |=> !listening) else $error("listener kept after unlisten");
  unt_drops_talk_a:
    assert property (atn_byte(`UNIVERSAL_UNT) |=> !talking) else $error("talker kept after untalk");
  own_listen_a:
    assert property (alt_mode && bus_valid && bus_atn && bus_data[7:5] == `LISTEN_PREFIX && bus_data[0]
      && bus_data[4:1] == addr_switch[4:1] |=> listening) else $error("command listen address missed");
  find_cause_a:
    assert property (find_start |-> $past(bus_valid && (bus_atn ? bus_data == `UNIVERSAL_UNL
      : (bus_data == `ASCII_CR || bus_eoi)))) else $error("find started without terminator");
  mode_select_a:
    assert property (!$past(rst) |-> alt_mode == $past(online && addressing_scheme_switch))
      else $error("addressing mode wrong");
  tx_hold_a:
    assert property (tx_valid && !tx_ready && !(bus_valid && bus_atn) |=> tx_valid && $stable(tx_data)
      && $stable(tx_eoi)) else $error("talker byte dropped before accept");
  tx_start_a:
    assert property ($rose(tx_valid) |-> $past(talking)) else $error("byte sent while not talker");
  sec_decode_a:
    assert property (sec_cmd_valid |-> !alt_mode && sec_cmd == $past(bus_data[4:0])
      && $past(bus_valid && bus_atn && bus_data[7:5] == `SECONDARY_PREFIX)) else $error("bad secondary");
  wr_data_a:
    assert property (wr_valid |-> wr_data == $past(bus_data) && $past(bus_valid && !bus_atn && listening))
      else $error("tape write not from listened byte");
endmodule // gpib_tape_command_decoder_chk
bind gpib_tape_command_decoder gpib_tape_command_decoder_chk chk_u (.*);

// *** tape_file_model.sv ***
// Tape file source and bus listener in front of the decoder
`timescale 1ns/1ps
module tape_file_model (
  // Clock, reset and control
  input wire       clk_sys, rst, start, slow, tape_ready,
  input wire [7:0] file_len,
  // File bytes and listener handshake
  output reg       tape_valid, tape_last, tx_ready,
  output reg [7:0] tape_data
);
  reg [7:0] idx_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idx_q <= 8'h00;
      tape_valid <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      // Slow listener accepts every other cycle
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (start) begin
        idx_q <= 8'h00;
        tape_valid <= 1'b1;
      end else if (tape_ready && tape_valid) begin
        idx_q <= idx_q + 8'h01;
        tape_valid <= (idx_q + 8'h01 != file_len);
      end
    end
  end
  // Stale data inverted so nothing relies on an absent byte
  always @* begin
    tape_last = tape_valid && (idx_q == file_len - 8'h01);
    tape_data = tape_valid ? 8'h30 + idx_q : ~(8'h30 + idx_q);
  end
endmodule // tape_file_model

// *** gpib_tape_command_decoder_test.sv ***
// Self-checking bench for the tape command decoder
`timescale 1ns/1ps
module gpib_tape_command_decoder_test;
  reg         clk_sys, rst, online, addressing_scheme_switch, bus_valid, bus_atn, bus_eoi, start, slow, eoi_q;
  reg  [4:0]  addr_switch, sec_q;
  reg  [7:0]  bus_data, file_len, wr_q;
  reg  [15:0] find_n, wr_n, info_n, tx_n, find_q;
  wire        tape_valid, tape_last, tape_ready, tx_valid, tx_eoi, tx_ready, wr_valid;
  wire        find_start, info_request, sec_cmd_valid, alt_mode, talking, listening;
  wire [7:0]  tape_data, tx_data, wr_data;
  wire [15:0] find_file;
  wire [4:0]  sec_cmd;
  integer     compares, miscompares, i;
  localparam [31:0] info_letters = "ETHS";
  gpib_tape_command_decoder dut_u (.*);
  tape_file_model far_u (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========
  // Output capture
  always @(posedge clk_sys) begin
    if (rst) begin
      {find_n, wr_n, info_n, tx_n, eoi_q} <= 65'h0;
      sec_q <= 5'h1f;
    end else begin
      if (find_start) {find_n, find_q} <= {find_n + 16'h1, find_file};
      if (wr_valid) {wr_n, wr_q} <= {wr_n + 16'h1, wr_data};
      if (info_request) info_n <= info_n + 16'h1;
      if (sec_cmd_valid) sec_q <= sec_cmd;
      if (tx_valid && tx_ready) {tx_n, eoi_q} <= {tx_n + 16'h1, tx_eoi};
    end
  end
  // ==========
  // Helpers
  task check(input string name, input [15:0] got, input [15:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0s exp %h got %h", name, exp, got);
    end
  endtask
  task send(input a, input [7:0] d, input e);
    {bus_valid, bus_atn, bus_data, bus_eoi} <= {1'b1, a, d, e};
    @(posedge clk_sys);
  endtask
  task idle(input integer n);
    {bus_valid, bus_atn, bus_eoi} <= 3'h0;
    repeat (n) @(posedge clk_sys);
  endtask
  task cmd(input [7:0] a, input [23:0] s, input e, input u);
    send(1'b1, a, 1'b0);
    send(1'b0, s[23:16], 1'b0);
    send(1'b0, s[15:8], 1'b0);
    send(1'b0, s[7:0], e);
    if (!e) send(1'b0, 8'h0d, 1'b0);
    if (u) send(1'b1, 8'h3f, 1'b0);
    idle(3);
  endtask
  task summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========
  // Scenarios
  task find_test;
    check("alt_on", alt_mode, 16'h1);
    send(1'b1, 8'h23, 1'b0);
    send(1'b1, 8'h60, 1'b0);
    cmd(8'h23, "F15", 1'b0, 1'b1);
    check("find_file", find_q, 16'd15);
    check("alt_sec", sec_q, 16'h1f);
    cmd(8'h23, "F?7", 1'b1, 1'b0);
    check("no_unl", find_n, 16'd1);
    send(1'b1, 8'h3f, 1'b0);
    idle(3);
    check("find_eoi", find_q, 16'd7);
  endtask
  task xfer_test(input [7:0] len, input [7:0] stop);
    reg [15:0] n0;
    cmd(8'h23, "INP", 1'b0, 1'b1);
    check("pending", tx_n, 16'd0 + (len == 8'h05 ? 16'd0 : 16'd5));
    {file_len, start, slow} <= {len, 1'b1, len == 8'h05};
    send(1'b1, 8'h42, 1'b0);
    start <= 1'b0;
    idle(8);
    if (stop == 8'h00) repeat (200) if (!eoi_q) @(posedge clk_sys);
    if (stop != 8'h00) send(1'b1, stop, 1'b0);
    send(1'b1, 8'h3f, 1'b0);
    idle(2);
    n0 = tx_n;
    idle(30);
    check("tx_count", tx_n, stop == 8'h00 ? 16'd5 : n0);
    if (stop != 8'h00) check("tx_cut", {15'h0000, tx_n < 16'd45}, 16'h1);
    check("talk_off", talking, 16'h0);
    if (stop == 8'h00) check("eoi", eoi_q, 16'h1);
  endtask
  task write_test;
    cmd(8'h23, "PUT", 1'b0, 1'b1);
    send(1'b1, 8'h22, 1'b0);
    send(1'b0, "F", 1'b0);
    send(1'b0, "9", 1'b0);
    send(1'b1, 8'h3f, 1'b0);
    idle(3);
    check("wr_n", wr_n, 16'd2);
    check("wr_q", wr_q, "9");
    cmd(8'h25, "F33", 1'b0, 1'b1);
    check("foreign", find_n, 16'd2);
  endtask
  task info_test;
    reg [15:0] n0;
    n0 = tx_n;
    for (i = 0; i < 4; i = i + 1) begin
      cmd(8'h23, {info_letters[8 * (3 - i) +: 8], 16'h2020}, 1'b0, 1'b1);
      send(1'b1, 8'h43, 1'b0);
      idle(3);
      check("info_n", info_n, 16'd1 + i[15:0]);
      check("info_quiet", tx_n, n0);
      send(1'b1, 8'h5f, 1'b0);
    end
  endtask
  task sec_test;
    addressing_scheme_switch <= 1'b0;
    idle(3);
    check("alt_off", alt_mode, 16'h0);
    send(1'b1, 8'h23, 1'b0);
    send(1'b1, 8'h78, 1'b0);
    idle(2);
    check("sec_cmd", sec_q, 16'h18);
    send(1'b0, "4", 1'b0);
    send(1'b0, 8'h0d, 1'b0);
    idle(3);
    check("sec_find", find_q, 16'd4);
    send(1'b1, 8'h23, 1'b0);
    send(1'b1, 8'h78, 1'b0);
    send(1'b0, "1", 1'b0);
    send(1'b0, "2", 1'b1);
    idle(3);
    check("sec_eoi", find_q, 16'd12);
  endtask
  initial begin
    {rst, online, addressing_scheme_switch} = 3'h7;
    {bus_valid, bus_atn, bus_eoi, start, slow, bus_data, file_len} = 21'h0;
    addr_switch = 5'h03;
    {compares, miscompares} = 64'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    idle(2);
    find_test;
    xfer_test(8'h05, 8'h00);
    xfer_test(8'h28, 8'h45);
    write_test;
    info_test;
    sec_test;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares = miscompares + 1;
    summarize;
  end
endmodule // gpib_tape_command_decoder_test
